// ==== rtap_pkg.sv ====
// rtap_pkg: constants and carriers for the adaptation / frequency-error register slice.
// assumes an 8-bit management register port with byte addresses in the channel map.
package rtap_pkg;
  // ==========================================================
  // register offsets
  localparam logic [7:0] RTAP_OFS_PPM_TAP1 = 8'h35;
  localparam logic [7:0] RTAP_OFS_EYE_CAPDAC = 8'h36;
  localparam logic [7:0] RTAP_OFS_EQ_STAT = 8'h37;
  localparam logic [7:0] RTAP_OFS_FB_STAT = 8'h38;
  localparam logic [7:0] RTAP_OFS_START_IDX = 8'h39;
  localparam logic [7:0] RTAP_OFS_FIX_BOOST = 8'h3A;
  localparam logic [7:0] RTAP_OFS_FCNT_HI = 8'h3B;
  localparam logic [7:0] RTAP_OFS_FCNT_LO = 8'h3C;
  localparam logic [7:0] RTAP_OFS_RSVD_3D = 8'h3D;
  localparam logic [7:0] RTAP_OFS_MON_CTRL = 8'h3E;
  // ==========================================================
  // reset values
  localparam logic [7:0] RTAP_RST_PPM_TAP1 = 8'h1F;
  localparam logic [7:0] RTAP_RST_EYE_CAPDAC = 8'h33;
  localparam logic [7:0] RTAP_RST_START_IDX = 8'h00;
  localparam logic [7:0] RTAP_RST_FIX_BOOST = 8'hA5;
  localparam logic [7:0] RTAP_RST_RSVD_3D = 8'h00;
  localparam logic [7:0] RTAP_RST_MON_CTRL = 8'h80;
  // ==========================================================
  // field positions
  localparam int RTAP_BIT_PPM_REQ = 5;
  localparam int RTAP_BIT_EYE_IRQ_EN = 6;
  localparam int RTAP_BIT_CAPDAC_OVR = 2;
  localparam int RTAP_BIT_MON_EN = 7;
  localparam int RTAP_BIT_START_EN = 3;
  localparam logic [7:0] RTAP_MASK_PPM_TAP1 = 8'h3F;
  localparam logic [7:0] RTAP_MASK_START_IDX = 8'h1F;
  localparam logic [7:0] RTAP_MASK_MON_CTRL = 8'h80;
  // ==========================================================
  // carriers
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rtap_reg_req_t;
  typedef struct packed {
    logic [4:0] tap1_limit;
    logic [1:0] capdac_range;
    logic [4:0] start_index;
    logic start_index_valid;
    logic [7:0] boost;
    logic boost_fixed;
  } rtap_eq_ctrl_t;
endpackage

// ==== rtap_regs.sv ====
// rtap_regs: register slice for frequency-error trigger, tap limit, cap dac override,
// adaptation start index, fixed low-rate boost and eye lock monitoring.
// assumes core status inputs are on i_clk; lock detectors and divide-rate info come from the core.
`timescale 1ns/1ns
// Notes on behaviour
// R01: request bit starts error compute, self-clears after
// R02: first tap magnitude clamped to 5-bit ceiling
// R03: override bit selects programmed cap dac range
// R04: start index used only when enable set
// R05: four 2-bit boost fields, stage 0 top
// R06: divide 4/8 rates use fixed boost, no adapt
// R07: software should zero boost for short channels
// R08: monitoring enabled starts after both locks declared
// R09: one eye check per programmed interval
// R10: 16-bit count readable as high/low bytes
// R11: eye interrupt passes only when enabled
module rtap_regs (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // register port
  input wire rtap_pkg::rtap_reg_req_t i_req,
  output logic [7:0] o_rdata,
  // core status
  input wire logic i_ppm_done,
  input wire logic [15:0] i_freq_count,
  input wire logic [7:0] i_eq_status,
  input wire logic [7:0] i_fb_status,
  input wire logic [1:0] i_capdac_auto,
  input wire logic i_start_en,
  input wire logic i_low_rate,
  input wire logic i_coarse_lock,
  input wire logic i_fine_lock,
  input wire logic i_adapt_done,
  input wire logic i_interval_tick,
  input wire logic i_eye_irq_raw,
  // core controls
  output logic o_ppm_start,
  output rtap_pkg::rtap_eq_ctrl_t o_eq_ctrl,
  output logic o_adapt_en,
  output logic o_mon_active,
  output logic o_eye_check,
  output logic o_eye_irq
);
  import rtap_pkg::*;

  // ==========================================================
  // storage
  logic [7:0] ppm_tap1_r, ppm_tap1_nxt; // request bit plus tap limit
  logic [7:0] eye_capdac_r; // irq enable and cap dac fields
  logic [7:0] start_idx_r; // adaptation start index
  logic [7:0] boost_r; // fixed boost per stage
  logic [7:0] rsvd_3d_r; // reserved, read back as written
  logic [7:0] mon_ctrl_r; // monitor enable
  logic [15:0] fcnt_r; // captured frequency count
  logic busy_r; // computation in flight
  logic [7:0] rdata_nxt;

  // ==========================================================
  // decode
  wire wr_35 = i_req.wr && (i_req.addr == RTAP_OFS_PPM_TAP1);
  wire wr_36 = i_req.wr && (i_req.addr == RTAP_OFS_EYE_CAPDAC);
  wire wr_39 = i_req.wr && (i_req.addr == RTAP_OFS_START_IDX);
  wire wr_3a = i_req.wr && (i_req.addr == RTAP_OFS_FIX_BOOST);
  wire wr_3d = i_req.wr && (i_req.addr == RTAP_OFS_RSVD_3D);
  wire wr_3e = i_req.wr && (i_req.addr == RTAP_OFS_MON_CTRL);
  // a fresh request is a write of one to the request bit while idle, or in the cycle that done clears it;
  // without the second term a write landing on done would leave the bit set with nothing running
  wire req_set = wr_35 && i_req.wdata[RTAP_BIT_PPM_REQ] &&
                 (!ppm_tap1_r[RTAP_BIT_PPM_REQ] || (busy_r && i_ppm_done));
  wire both_lock = i_coarse_lock && i_fine_lock;
  wire mon_on = mon_ctrl_r[RTAP_BIT_MON_EN] && both_lock; // R08
  wire [1:0] capdac_sel = eye_capdac_r[RTAP_BIT_CAPDAC_OVR] ? eye_capdac_r[1:0] : i_capdac_auto; // R03
  wire start_valid = i_start_en; // R04

  // ==========================================================
  // request bit: done clears, a new write of one wins over done
  always_comb begin
    ppm_tap1_nxt = ppm_tap1_r;
    if (wr_35) begin
      ppm_tap1_nxt[4:0] = i_req.wdata[4:0];
    end
    if (busy_r && i_ppm_done) begin
      ppm_tap1_nxt[RTAP_BIT_PPM_REQ] = 1'b0; // R01
    end
    if (wr_35 && i_req.wdata[RTAP_BIT_PPM_REQ]) begin
      ppm_tap1_nxt[RTAP_BIT_PPM_REQ] = 1'b1; // R01
    end
  end

  // ==========================================================
  // read mux, unmapped offsets read zero; reserved 3D reads back as written
  always_comb begin
    unique case (i_req.addr)
      RTAP_OFS_PPM_TAP1: rdata_nxt = ppm_tap1_r & RTAP_MASK_PPM_TAP1;
      RTAP_OFS_EYE_CAPDAC: rdata_nxt = eye_capdac_r;
      RTAP_OFS_EQ_STAT: rdata_nxt = i_eq_status;
      RTAP_OFS_FB_STAT: rdata_nxt = i_fb_status;
      RTAP_OFS_START_IDX: rdata_nxt = start_idx_r & RTAP_MASK_START_IDX;
      RTAP_OFS_FIX_BOOST: rdata_nxt = boost_r;
      RTAP_OFS_FCNT_HI: rdata_nxt = fcnt_r[15:8]; // R10
      RTAP_OFS_FCNT_LO: rdata_nxt = fcnt_r[7:0]; // R10
      RTAP_OFS_RSVD_3D: rdata_nxt = rsvd_3d_r;
      RTAP_OFS_MON_CTRL: rdata_nxt = mon_ctrl_r & RTAP_MASK_MON_CTRL;
      default: rdata_nxt = 8'h00;
    endcase
  end

  // ==========================================================
  // writable registers
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      ppm_tap1_r <= RTAP_RST_PPM_TAP1; // R02
      eye_capdac_r <= RTAP_RST_EYE_CAPDAC;
      start_idx_r <= RTAP_RST_START_IDX;
      boost_r <= RTAP_RST_FIX_BOOST; // R05
      rsvd_3d_r <= RTAP_RST_RSVD_3D;
      mon_ctrl_r <= RTAP_RST_MON_CTRL;
    end else begin
      ppm_tap1_r <= ppm_tap1_nxt;
      if (wr_36) eye_capdac_r <= i_req.wdata;
      if (wr_39) start_idx_r <= i_req.wdata;
      if (wr_3a) boost_r <= i_req.wdata; // R07
      if (wr_3d) rsvd_3d_r <= i_req.wdata;
      if (wr_3e) mon_ctrl_r <= i_req.wdata;
    end
  end

  // ==========================================================
  // frequency-error sequencing; the count is captured when done
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      busy_r <= 1'b0;
      fcnt_r <= 16'h0000;
      o_ppm_start <= 1'b0;
    end else begin
      o_ppm_start <= req_set; // R01
      if (req_set) busy_r <= 1'b1;
      else if (i_ppm_done) busy_r <= 1'b0;
      if (busy_r && i_ppm_done) fcnt_r <= i_freq_count; // R10
    end
  end

  // ==========================================================
  // outputs to the equalizer core, all registered
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_rdata <= 8'h00;
      o_eq_ctrl <= '0;
      o_adapt_en <= 1'b0;
      o_mon_active <= 1'b0;
      o_eye_check <= 1'b0;
      o_eye_irq <= 1'b0;
    end else begin
      o_rdata <= rdata_nxt;
      o_eq_ctrl.tap1_limit <= ppm_tap1_r[4:0]; // R02
      o_eq_ctrl.capdac_range <= capdac_sel; // R03
      o_eq_ctrl.start_index <= start_idx_r[4:0]; // R04
      o_eq_ctrl.start_index_valid <= start_valid; // R04
      o_eq_ctrl.boost <= boost_r; // R05
      o_eq_ctrl.boost_fixed <= i_low_rate; // R06
      o_adapt_en <= !i_low_rate; // R06
      o_mon_active <= mon_on; // R08
      o_eye_check <= mon_on && i_adapt_done && i_interval_tick; // R09
      o_eye_irq <= i_eye_irq_raw && eye_capdac_r[RTAP_BIT_EYE_IRQ_EN]; // R11
    end
  end

  // ==========================================================
  // checks
  property p_ppm_clear;
    @(posedge i_clk) disable iff (i_sys_rst)
      (busy_r && i_ppm_done && !wr_35) |=> !ppm_tap1_r[RTAP_BIT_PPM_REQ];
  endproperty
  a_ppm_clear: assert property (p_ppm_clear) else $error("request bit not cleared"); // R01
  property p_ppm_start;
    @(posedge i_clk) disable iff (i_sys_rst)
      req_set |=> o_ppm_start ##1 (!o_ppm_start || $past(req_set));
  endproperty
  a_ppm_start: assert property (p_ppm_start) else $error("start pulse wrong"); // R01
  property p_tap1;
    @(posedge i_clk) disable iff (i_sys_rst) 1'b1 |=> o_eq_ctrl.tap1_limit == $past(ppm_tap1_r[4:0]);
  endproperty
  a_tap1: assert property (p_tap1) else $error("tap limit mismatch"); // R02
  property p_capdac;
    @(posedge i_clk) disable iff (i_sys_rst)
      eye_capdac_r[RTAP_BIT_CAPDAC_OVR] |=> o_eq_ctrl.capdac_range == $past(eye_capdac_r[1:0]);
  endproperty
  a_capdac: assert property (p_capdac) else $error("override range ignored"); // R03
  property p_start;
    @(posedge i_clk) disable iff (i_sys_rst) !i_start_en |=> !o_eq_ctrl.start_index_valid;
  endproperty
  a_start: assert property (p_start) else $error("start index used without enable"); // R04
  property p_boost;
    @(posedge i_clk) disable iff (i_sys_rst) wr_3a |=> ##1 o_eq_ctrl.boost == $past(i_req.wdata, 2);
  endproperty
  a_boost: assert property (p_boost) else $error("boost not applied"); // R05
  property p_lowrate;
    @(posedge i_clk) disable iff (i_sys_rst) i_low_rate |=> !o_adapt_en && o_eq_ctrl.boost_fixed;
  endproperty
  a_lowrate: assert property (p_lowrate) else $error("adapting at low rate"); // R06
  property p_mon;
    @(posedge i_clk) disable iff (i_sys_rst) !(i_coarse_lock && i_fine_lock) |=> !o_mon_active;
  endproperty
  a_mon: assert property (p_mon) else $error("monitor before lock"); // R08
  property p_check;
    @(posedge i_clk) disable iff (i_sys_rst) o_eye_check |-> $past(i_interval_tick && i_adapt_done);
  endproperty
  a_check: assert property (p_check) else $error("eye check off interval"); // R09
  property p_fcnt;
    @(posedge i_clk) disable iff (i_sys_rst)
      (i_req.addr == RTAP_OFS_FCNT_HI) |=> o_rdata == $past(fcnt_r[15:8]);
  endproperty
  a_fcnt: assert property (p_fcnt) else $error("count high byte wrong"); // R10
  property p_irq;
    @(posedge i_clk) disable iff (i_sys_rst) !eye_capdac_r[RTAP_BIT_EYE_IRQ_EN] |=> !o_eye_irq;
  endproperty
  a_irq: assert property (p_irq) else $error("irq while disabled"); // R11
  c_ppm: cover property (@(posedge i_clk) disable iff (i_sys_rst) req_set ##[1:20] (busy_r && i_ppm_done));
  c_irq: cover property (@(posedge i_clk) disable iff (i_sys_rst) o_eye_irq);
  c_check: cover property (@(posedge i_clk) disable iff (i_sys_rst) o_eye_check);
  // new request landing in the done cycle
  c_restart: cover property (@(posedge i_clk) disable iff (i_sys_rst) req_set && busy_r && i_ppm_done);
endmodule

// ==== rtap_tb.sv ====
// rtap_tb: self-checking bench for the rtap_regs register slice.
// assumes rtap_pkg is compiled first; all inputs change on the falling edge.
`timescale 1ns/1ns
module tb;
  import rtap_pkg::*;
  // ==========================================================
  // stimulus table type: offset, reset read, write data, read after write
  typedef struct packed {
    logic [7:0] a;
    logic [7:0] rst;
    logic [7:0] wd;
    logic [7:0] wexp;
  } rtap_tb_row_t;
  // ==========================================================
  // design signals
  logic i_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  rtap_reg_req_t i_req = '0;
  logic [7:0] o_rdata;
  logic i_ppm_done = 1'b0;
  logic [15:0] i_freq_count = 16'h0000;
  logic [1:0] i_capdac_auto = 2'h2;
  logic i_start_en = 1'b0;
  logic i_low_rate = 1'b0;
  logic i_coarse_lock = 1'b0;
  logic i_fine_lock = 1'b0;
  logic i_adapt_done = 1'b0;
  logic i_interval_tick = 1'b0;
  logic i_eye_irq_raw = 1'b0;
  logic o_ppm_start;
  logic o_adapt_en;
  logic o_mon_active;
  logic o_eye_check;
  logic o_eye_irq;
  rtap_eq_ctrl_t o_eq_ctrl;
  // counters: mismatches, compares, pulse tallies, cycles
  int err_total = 0;
  int n_compared = 0;
  int n_start = 0;
  int n_check = 0;
  int n_cyc = 0;
  // status levels are fixed patterns so a byte swap would show
  rtap_tb_row_t rows [11] = '{
    '{8'h35, 8'h1F, 8'h0A, 8'h0A}, '{8'h36, 8'h33, 8'h45, 8'h45},
    '{8'h37, 8'h5A, 8'hFF, 8'h5A}, '{8'h38, 8'hC3, 8'hFF, 8'hC3},
    '{8'h39, 8'h00, 8'hFF, 8'h1F}, '{8'h3A, 8'hA5, 8'h00, 8'h00},
    '{8'h3B, 8'h00, 8'hFF, 8'h00}, '{8'h3C, 8'h00, 8'hFF, 8'h00},
    '{8'h3D, 8'h00, 8'h81, 8'h81}, '{8'h3E, 8'h80, 8'h7F, 8'h00},
    '{8'h40, 8'h00, 8'hFF, 8'h00}};
  // ==========================================================
  // design under test
  rtap_regs i_dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_req(i_req), .o_rdata(o_rdata),
    .i_ppm_done(i_ppm_done), .i_freq_count(i_freq_count), .i_eq_status(8'h5A), .i_fb_status(8'hC3),
    .i_capdac_auto(i_capdac_auto), .i_start_en(i_start_en), .i_low_rate(i_low_rate),
    .i_coarse_lock(i_coarse_lock), .i_fine_lock(i_fine_lock), .i_adapt_done(i_adapt_done),
    .i_interval_tick(i_interval_tick), .i_eye_irq_raw(i_eye_irq_raw), .o_ppm_start(o_ppm_start),
    .o_eq_ctrl(o_eq_ctrl), .o_adapt_en(o_adapt_en), .o_mon_active(o_mon_active),
    .o_eye_check(o_eye_check), .o_eye_irq(o_eye_irq));
  // 100 ns period clock
  always #50 i_clk = ~i_clk;
  // pulse tallies and hang guard; counting avoids guessing the pulse's exact cycle
  // taken at the falling edge, where registered outputs have settled
  always @(negedge i_clk) begin
    n_cyc++;
    if (o_ppm_start === 1'b1) n_start++;
    if (o_eye_check === 1'b1) n_check++;
    if (n_cyc >= 2000) begin
      err_total++;
      conclude();
    end
  end
  // ==========================================================
  // shared tasks
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // one-cycle write pulse, entered at a falling edge; an idle cycle follows
  // so back-to-back calls never lower and raise the strobe in one step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_req.wr = 1'b1;
    i_req.addr = a;
    i_req.wdata = d;
    @(negedge i_clk);
    i_req.wr = 1'b0;
    @(negedge i_clk);
  endtask
  // read data is registered, so look one cycle after the address
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    i_req.addr = a;
    @(negedge i_clk);
    check($sformatf("rdata_%h", a), o_rdata, e);
  endtask
  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // ==========================================================
  // main sequence
  initial begin
    repeat (10) @(negedge i_clk);
    i_sys_rst = 1'b0;
    @(negedge i_clk);
    // reset values, write masks, read-only and unmapped places
    foreach (rows[k]) begin
      rd(rows[k].a, rows[k].rst);
      wr(rows[k].a, rows[k].wd);
      rd(rows[k].a, rows[k].wexp);
    end
    // controls seen by the core
    i_start_en = 1'b1;
    i_eye_irq_raw = 1'b1;
    repeat (2) @(negedge i_clk);
    check("tap1", o_eq_ctrl.tap1_limit, 5'h0A);
    check("capdac_ovr", o_eq_ctrl.capdac_range, 2'h1);
    check("start_idx", {o_eq_ctrl.start_index, o_eq_ctrl.start_index_valid}, 6'h3F);
    check("irq_on", o_eye_irq, 1'b1);
    wr(8'h36, 8'h00);
    i_low_rate = 1'b1;
    i_start_en = 1'b0;
    repeat (2) @(negedge i_clk);
    check("capdac_auto", o_eq_ctrl.capdac_range, 2'h2);
    check("irq_off", o_eye_irq, 1'b0);
    check("low_rate", {o_eq_ctrl.boost, o_eq_ctrl.boost_fixed, o_eq_ctrl.start_index_valid, o_adapt_en}, 11'h004);
    // frequency error request, repeated while busy, then done
    wr(8'h35, 8'h2A);
    wr(8'h35, 8'h2A);
    rd(8'h35, 8'h2A);
    i_freq_count = 16'hBEEF;
    i_ppm_done = 1'b1;
    @(negedge i_clk);
    i_ppm_done = 1'b0;
    rd(8'h35, 8'h0A);
    rd(8'h3B, 8'hBE);
    rd(8'h3C, 8'hEF);
    check("starts", n_start, 1);
    // a new request landing in the done cycle restarts instead of sticking
    wr(8'h35, 8'h2A);
    i_ppm_done = 1'b1;
    i_req.wr = 1'b1;
    @(negedge i_clk);
    i_ppm_done = 1'b0;
    i_req.wr = 1'b0;
    @(negedge i_clk);
    rd(8'h35, 8'h2A);
    i_ppm_done = 1'b1;
    @(negedge i_clk);
    i_ppm_done = 1'b0;
    rd(8'h35, 8'h0A);
    check("restarts", n_start, 3);
    // lock monitoring needs both detectors
    wr(8'h3E, 8'h80);
    i_coarse_lock = 1'b1;
    repeat (2) @(negedge i_clk);
    check("mon_half", o_mon_active, 1'b0);
    i_fine_lock = 1'b1;
    i_adapt_done = 1'b1;
    repeat (2) @(negedge i_clk);
    check("mon_on", o_mon_active, 1'b1);
    i_interval_tick = 1'b1;
    @(negedge i_clk);
    i_interval_tick = 1'b0;
    repeat (3) @(negedge i_clk);
    check("eye_checks", n_check, 1);
    // monitor enable cleared: locks alone must not monitor or check
    wr(8'h3E, 8'h00);
    check("mon_off", o_mon_active, 1'b0);
    i_interval_tick = 1'b1;
    @(negedge i_clk);
    i_interval_tick = 1'b0;
    repeat (2) @(negedge i_clk);
    check("eye_checks_off", n_check, 1);
    // second reset in mid-run restores defaults
    i_sys_rst = 1'b1;
    repeat (10) @(negedge i_clk);
    i_sys_rst = 1'b0;
    @(negedge i_clk);
    rd(8'h3A, 8'hA5);
    rd(8'h3E, 8'h80);
    conclude();
  end
endmodule
